// ==== dv/padh_core_tb.sv ====
// Directed bench for the port block over its register port.
// Assumes the partner model on port 1; port 2 loops back to itself.
`timescale 1ns/1ps
module padh_core_tb;
    import padh_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    padh_req_t req = '0;
    logic [7:0] rdata, p1_in, p1_out, p1_oe, p0_out, p0_oe, p2_out, p2_oe, v;
    logic as_n, as_oe, ds_n, ds_oe, rw, rw_oe, l3, l4, l6, emi1, emi2;
    logic l1 = 1'b1; // Port 2 partner line, idle high
    int fails = 0;
    int n_checks = 0;
    int ds_lo = 0; // Data strobe low cycles of the last bus cycle
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (!ds_n) ds_lo++;
    padh_core dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
        .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p0_out(p0_out),
        .p0_oe(p0_oe), .address_strobe_n(as_n), .address_strobe_oe(as_oe),
        .data_strobe_n(ds_n), .data_strobe_oe(ds_oe), .bus_read_nwrite(rw),
        .bus_read_nwrite_oe(rw_oe), .p2_in(p2_out), .p2_out(p2_out),
        .p2_oe(p2_oe), .port3_line_three(l3), .port3_line_four(l4),
        .port3_line_one(l1), .port3_line_six(l6), .p1_low_emi(emi1),
        .p2_low_emi(emi2));
    padh_partner mem (.clk(clk), .p1_out(p1_out), .p1_oe(p1_oe),
        .data_strobe_n(ds_n), .port3_line_four(l4), .p1_in(p1_in),
        .port3_line_three(l3));
    // ----------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 v = rdata;
        chk(v, e);
    endtask
    // Bounded wait for idle, then strobe width
    task fin(input int n);
        v = 8'h01;
        for (int i = 0; i < 200 && v[0] !== 1'b0; i++) begin
            @(posedge clk) req <= '{1'b0, 1'b1, OFF_BUS_CTRL, 8'h00};
            @(posedge clk) req <= '0;
            #1 v = rdata;
        end
        chk(v, 8'h00);
        chk(8'(ds_lo), 8'(n));
    endtask
    task end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles
    initial begin
        #40000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rc(OFF_P1_DIR, 8'hFF);
        rc(OFF_CFG0, 8'h00);
        wr(OFF_P1_DIR, 8'h00);
        wr(OFF_P1_DATA, 8'h55);
        chk(p1_oe, 8'hFF);
        chk(p1_out, 8'h55);
        wr(OFF_CFG0, 8'h68);
        chk(p1_oe, 8'hAA);
        chk({6'h0, emi2, emi1}, 8'h03);
        wr(OFF_P2_DIR, 8'h0F);
        wr(OFF_P2_DATA, 8'h3C);
        chk(p2_oe, 8'hF0);
        chk(p2_out, 8'h3C);
        wr(OFF_CFG0, 8'h10);
        chk(p2_oe, 8'hC0);
        // Start outside bus mode is refused
        wr(OFF_BUS_CTRL, 8'h01);
        rc(OFF_BUS_CTRL, 8'h00);
        wr(OFF_CFG0, 8'h01);
        wr(OFF_CFG1, 8'h02);
        wr(OFF_BUS_ADDR_HI, 8'h12);
        wr(OFF_BUS_ADDR_LO, 8'h34);
        wr(OFF_BUS_WDATA, 8'hA5);
        chk({4'h0, as_oe, ds_oe, rw_oe, |p1_oe}, 8'h0E);
        ds_lo = 0;
        wr(OFF_BUS_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        #1 chk(p1_out, 8'h34);
        chk(p0_out, 8'h12);
        chk(p0_oe, 8'hFF);
        chk({7'h0, rw}, 8'h00);
        fin(C_DS_WRITE);
        ds_lo = 0;
        wr(OFF_BUS_CTRL, 8'h03);
        fin(C_DS_READ);
        rc(OFF_BUS_RDATA, 8'hC3);
        wr(OFF_CFG0, 8'h81);
        ds_lo = 0;
        wr(OFF_BUS_CTRL, 8'h01);
        fin(C_DS_WRITE + C_EXT);
        ds_lo = 0;
        wr(OFF_BUS_CTRL, 8'h03);
        fin(C_DS_READ + C_EXT);
        rc(OFF_BUS_RDATA, 8'hC3);
        wr(OFF_CFG1, 8'h03);
        chk({3'h0, as_oe, ds_oe, rw_oe, |p1_oe, |p0_oe}, 8'h00);
        wr(OFF_BUS_CTRL, 8'h01);
        rc(OFF_BUS_CTRL, 8'h00);
        wr(OFF_CFG1, 8'h00);
        wr(OFF_CFG0, 8'h02);
        wr(OFF_P1_DATA, 8'h5A);
        chk({p1_out[7:1], l4}, 8'h5A);
        rc(OFF_HS_STAT, 8'h01);
        repeat (12) @(posedge clk);
        #1 chk({7'h0, l4}, 8'h01);
        rc(OFF_HS_STAT, 8'h00);
        wr(OFF_CFG0, 8'h04);
        wr(OFF_P2_DATA, 8'h3C);
        chk({7'h0, l6}, 8'h00);
        // Partner ready pulse completes the send
        @(posedge clk) l1 <= 1'b0;
        @(posedge clk) l1 <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, l6}, 8'h01);
        rc(OFF_HS_STAT, 8'h00);
        wr(OFF_P2_DIR, 8'h8F);
        chk({7'h0, l6}, 8'h01);
        // Partner data-available pulse fills the receiver
        @(posedge clk) l1 <= 1'b0;
        @(posedge clk) l1 <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, l6}, 8'h00);
        rc(OFF_HS_STAT, 8'h02);
        // New pin levels must not replace the latched word
        wr(OFF_P2_DATA, 8'h5A);
        rc(OFF_P2_DATA, 8'h3C);
        chk({7'h0, l6}, 8'h01);
        end_sim();
    end
endmodule

// ==== dv/padh_partner.sv ====
// Far side model: external memory data source and port 1 ready partner.
// Assumes it sees the design's port 1 drive and resolves the wire itself.
`timescale 1ns/1ps
module padh_partner #(
    parameter logic [7:0] RD_WORD = 8'hC3
) (
    input wire logic clk,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe,
    input wire logic data_strobe_n,
    input wire logic port3_line_four,
    output logic [7:0] p1_in,
    output logic port3_line_three
);
    logic [2:0] lag = 3'h0; // Ready lags data-available by a few cycles
    // Memory drives only while the data strobe is low; a released bus
    // shows the inverse word, so a late or early sample is caught
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p1_in[i] = p1_oe[i] ? p1_out[i] :
                (!data_strobe_n ? RD_WORD[i] : !RD_WORD[i]);
        end
    end
    // Ready rises once data was seen, falls when it is withdrawn
    always_ff @(posedge clk) begin
        lag <= port3_line_four ? 3'h0 : (lag == 3'h3 ? lag : lag + 3'h1);
        port3_line_three <= (lag == 3'h3);
    end
endmodule

// ==== hw/padh_core.sv ====
// Two 8-bit ports: port 1 as I/O, address/data bus or handshake port,
// port 2 as per-bit I/O with handshake. Pins arrive asynchronous; the
// register port is on clk. Pin wires are resolved outside.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Contract
// - Port 1 per-line direction or multiplexed bus
// - Port 1 global push-pull or open-drain
// - Global low EMI select per port
// - Port 1 handshake on line three/four
// - Port 0 drives upper address lines
// - Bus pins float together for sharing
// - Port 2 per-line direction
// - Port 2 global push-pull or open-drain
// - Port 2 handshake on line one/six
// - Port 2 handshake follows bit 7 direction
// - Extended timing adds two clock periods
module padh_core
    import padh_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire padh_req_t req,
    output logic [7:0] rdata,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    output logic address_strobe_n,
    output logic address_strobe_oe,
    output logic data_strobe_n,
    output logic data_strobe_oe,
    output logic bus_read_nwrite,
    output logic bus_read_nwrite_oe,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    input wire logic port3_line_three,
    output logic port3_line_four,
    input wire logic port3_line_one,
    output logic port3_line_six,
    output logic p1_low_emi,
    output logic p2_low_emi
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] p1_data; // Port 1 output latch
        logic [7:0] p1_dir; // Port 1 direction, 1 = input
        logic [7:0] p2_data; // Port 2 output latch
        logic [7:0] p2_dir; // Port 2 direction, 1 = input
        logic [7:0] cfg0; // Mode and drive options
        logic [7:0] cfg1; // Bus sharing options
        logic [7:0] addr_lo; // Bus address, low byte
        logic [7:0] addr_hi; // Bus address, high byte
        logic [7:0] bus_wd; // Bus write data
        logic [7:0] bus_rd; // Bus read data
        logic cyc_rd; // Current cycle is a read
        logic cyc_ext; // Current cycle is extended
        padh_bus_state_t state; // Bus cycle sequencer
        logic [7:0] cnt; // Phase counter
        logic [7:0] s1_p1; // Synchroniser stages
        logic [7:0] s2_p1;
        logic [7:0] s1_p2;
        logic [7:0] s2_p2;
        logic [1:0] s1_hs;
        logic [1:0] s2_hs;
        logic [7:0] rdata; // Register read answer
        logic [7:0] o_p1_out; // Registered pin outputs
        logic [7:0] o_p1_oe;
        logic [7:0] o_p0_out;
        logic [7:0] o_p0_oe;
        logic o_as;
        logic o_ds;
        logic o_rw;
        logic o_ctl_oe;
        logic [7:0] o_p2_out;
        logic [7:0] o_p2_oe;
        logic o_emi1;
        logic o_emi2;
    } padh_core_st_t;

    localparam padh_core_st_t ST_RST = '{
        p1_dir: RST_DIR, p2_dir: RST_DIR, cfg0: RST_CFG, cfg1: RST_CFG,
        state: ST_IDLE, o_as: 1'b1, o_ds: 1'b1, o_rw: 1'b1, default: '0};

    padh_core_st_t st; // Registered state
    padh_core_st_t nxt; // Next state
    logic start; // Accepted bus cycle request
    padh_p1_mode_t mode; // Port 1 mode, current
    logic hs1_pend; // Port 1 send outstanding
    logic hs2_pend; // Port 2 transfer outstanding
    logic [7:0] hs2_data; // Port 2 received word
    logic [15:0] drv1; // Port 1 plain I/O drive
    logic [15:0] drv2; // Port 2 plain I/O drive

    initial begin
        if (PORT_W != 8) begin
            $error("padh_core: ports are eight bits wide");
        end
    end

    // Pin drive: open-drain only pulls low, inputs never drive
    function automatic logic [15:0] pin_drive(input logic [7:0] d,
            input logic [7:0] dir, input logic od);
        logic [7:0] o;
        logic [7:0] e;
        o = od ? 8'h00 : d;
        e = ~dir & (od ? ~d : 8'hFF);
        return {o, e};
    endfunction

    assign mode = padh_p1_mode_t'(st.cfg0[F0_MODE_LO +: 2]);

    // -------------------------------------------------------------
    // Handshake channels
    // -------------------------------------------------------------
    // Port 1 only sends; ready in on line three, valid out on four
    padh_hs #(.W(8)) u_hs1 (
        .clk(clk),
        .arst_n(arst_n),
        .en(mode == PM_HS),
        .dir_in(1'b0),
        .load(req.wr && req.addr == OFF_P1_DATA),
        .take(1'b0),
        .partner(st.s2_hs[1]),
        .pins(st.s2_p1),
        .hs_out(port3_line_four),
        .pending(hs1_pend),
        .latched()
    );

    // Port 2 direction follows its top bit
    padh_hs #(.W(8)) u_hs2 (
        .clk(clk),
        .arst_n(arst_n),
        .en(st.cfg0[F0_HS2]),
        .dir_in(st.p2_dir[7]),
        .load(req.wr && req.addr == OFF_P2_DATA),
        .take(req.rd && req.addr == OFF_P2_DATA),
        .partner(st.s2_hs[0]),
        .pins(st.s2_p2),
        .hs_out(port3_line_six),
        .pending(hs2_pend),
        .latched(hs2_data)
    );

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    // Registers, bus sequencer and pin drive in one pass
    always_comb begin
        nxt = st;
        // Two stages before anything looks at a pin
        nxt.s1_p1 = p1_in;
        nxt.s2_p1 = st.s1_p1;
        nxt.s1_p2 = p2_in;
        nxt.s2_p2 = st.s1_p2;
        nxt.s1_hs = {port3_line_three, port3_line_one};
        nxt.s2_hs = st.s1_hs;
        // A cycle only starts in bus mode with the bus owned
        start = req.wr && req.addr == OFF_BUS_CTRL && req.wdata[FC_START]
            && st.state == ST_IDLE && mode == PM_BUS
            && !st.cfg1[F1_FLOAT];
        // Register writes
        if (req.wr) begin
            case (req.addr)
                OFF_P1_DATA: nxt.p1_data = req.wdata;
                OFF_P1_DIR: nxt.p1_dir = req.wdata;
                OFF_P2_DATA: nxt.p2_data = req.wdata;
                OFF_P2_DIR: nxt.p2_dir = req.wdata;
                OFF_CFG0: nxt.cfg0 = req.wdata;
                OFF_CFG1: nxt.cfg1 = req.wdata;
                OFF_BUS_ADDR_LO: nxt.addr_lo = req.wdata;
                OFF_BUS_ADDR_HI: nxt.addr_hi = req.wdata;
                OFF_BUS_WDATA: nxt.bus_wd = req.wdata;
                default: ;
            endcase
        end
        // Bus cycle: address, strobe, gap, data strobe, hold
        case (st.state)
            ST_IDLE: begin
                if (start) begin
                    nxt.state = ST_ADDR;
                    nxt.cnt = C_ADDR_SETUP - 8'h01;
                    nxt.cyc_rd = req.wdata[FC_READ];
                    nxt.cyc_ext = st.cfg0[F0_EXT];
                end
            end
            ST_ADDR: begin
                nxt.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h00) begin
                    nxt.state = ST_AS;
                    nxt.cnt = C_AS_LOW - 8'h01;
                end
            end
            ST_AS: begin
                nxt.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h00) begin
                    nxt.state = ST_GAP;
                    nxt.cnt = C_AS_TO_DS - 8'h01;
                end
            end
            ST_GAP: begin
                nxt.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h00) begin
                    nxt.state = ST_DS;
                    nxt.cnt = (st.cyc_rd ? C_DS_READ : C_DS_WRITE)
                        + (st.cyc_ext ? C_EXT : 8'h00) - 8'h01;
                end
            end
            ST_DS: begin
                nxt.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h00) begin
                    // Sample before the strobe rises
                    if (st.cyc_rd) begin
                        nxt.bus_rd = st.s2_p1;
                    end
                    nxt.state = ST_END;
                    nxt.cnt = C_DS_HOLD - 8'h01;
                end
            end
            ST_END: begin
                nxt.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h00) begin
                    nxt.state = ST_IDLE;
                end
            end
            default: nxt.state = ST_IDLE;
        endcase
        // Read answer, unmapped offsets read zero
        nxt.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                OFF_P1_DATA: nxt.rdata = st.s2_p1;
                OFF_P1_DIR: nxt.rdata = st.p1_dir;
                OFF_P2_DATA: nxt.rdata = (st.cfg0[F0_HS2] && st.p2_dir[7])
                    ? hs2_data : st.s2_p2;
                OFF_P2_DIR: nxt.rdata = st.p2_dir;
                OFF_CFG0: nxt.rdata = st.cfg0;
                OFF_CFG1: nxt.rdata = st.cfg1;
                OFF_BUS_ADDR_LO: nxt.rdata = st.addr_lo;
                OFF_BUS_ADDR_HI: nxt.rdata = st.addr_hi;
                OFF_BUS_WDATA: nxt.rdata = st.bus_wd;
                OFF_BUS_CTRL: nxt.rdata = {7'h00, st.state != ST_IDLE};
                OFF_BUS_RDATA: nxt.rdata = st.bus_rd;
                OFF_HS_STAT: nxt.rdata = {6'h00, hs2_pend, hs1_pend};
                default: nxt.rdata = 8'h00;
            endcase
        end
        // Pin drive from the new state, so pins and state agree
        drv1 = pin_drive(nxt.p1_data, nxt.p1_dir, nxt.cfg0[F0_OD1]);
        drv2 = pin_drive(nxt.p2_data, nxt.p2_dir, nxt.cfg0[F0_OD2]);
        if (nxt.state == ST_IDLE) begin
            {nxt.o_p1_out, nxt.o_p1_oe} = drv1;
            if (nxt.cfg0[F0_MODE_LO +: 2] == PM_BUS) begin
                nxt.o_p1_oe = 8'h00;
            end
        end else if (nxt.state == ST_ADDR || nxt.state == ST_AS) begin
            nxt.o_p1_out = nxt.addr_lo;
            nxt.o_p1_oe = 8'hFF;
        end else begin
            // Read floats the lines, write drives the data
            nxt.o_p1_out = nxt.bus_wd;
            nxt.o_p1_oe = nxt.cyc_rd ? 8'h00 : 8'hFF;
        end
        nxt.o_p0_out = nxt.addr_hi;
        nxt.o_p0_oe = (nxt.state != ST_IDLE && nxt.cfg1[F1_HIADDR])
            ? 8'hFF : 8'h00;
        nxt.o_as = nxt.state != ST_AS;
        nxt.o_ds = nxt.state != ST_DS;
        nxt.o_rw = (nxt.state == ST_IDLE) ? 1'b1 : nxt.cyc_rd;
        nxt.o_ctl_oe = nxt.cfg0[F0_MODE_LO +: 2] == PM_BUS;
        // Release every shared line at once for another master
        if (nxt.cfg1[F1_FLOAT]) begin
            nxt.o_p1_oe = 8'h00;
            nxt.o_p0_oe = 8'h00;
            nxt.o_ctl_oe = 1'b0;
        end
        {nxt.o_p2_out, nxt.o_p2_oe} = drv2;
        nxt.o_emi1 = nxt.cfg0[F0_EMI1];
        nxt.o_emi2 = nxt.cfg0[F0_EMI2];
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_RST;
        end else begin
            st <= nxt;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign rdata = st.rdata;
    assign p1_out = st.o_p1_out;
    assign p1_oe = st.o_p1_oe;
    assign p0_out = st.o_p0_out;
    assign p0_oe = st.o_p0_oe;
    assign address_strobe_n = st.o_as;
    assign address_strobe_oe = st.o_ctl_oe;
    assign data_strobe_n = st.o_ds;
    assign data_strobe_oe = st.o_ctl_oe;
    assign bus_read_nwrite = st.o_rw;
    assign bus_read_nwrite_oe = st.o_ctl_oe;
    assign p2_out = st.o_p2_out;
    assign p2_oe = st.o_p2_oe;
    assign p1_low_emi = st.o_emi1;
    assign p2_low_emi = st.o_emi2;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_as_pulse;
        ##9 !address_strobe_n ##1 address_strobe_n;
    endsequence

    sequence s_ds_wr_ext;
        ##21 !data_strobe_n ##1 data_strobe_n;
    endsequence

    a_as_width: assert property ($fell(address_strobe_n) |-> s_as_pulse)
        else $error("address strobe width wrong");
    a_as_to_ds: assert property ($rose(address_strobe_n)
        |-> ##12 $fell(data_strobe_n))
        else $error("data strobe late or early");
    a_ds_ext_wr: assert property ($fell(data_strobe_n) && !bus_read_nwrite
        && st.cyc_ext |-> s_ds_wr_ext)
        else $error("extended write strobe wrong");
    a_ds_rd_base: assert property ($fell(data_strobe_n) && bus_read_nwrite
        && !st.cyc_ext |-> ##33 !data_strobe_n ##1 data_strobe_n)
        else $error("read strobe width wrong");
    a_float_all: assert property (st.cfg1[F1_FLOAT] |-> p1_oe == 8'h00
        && p0_oe == 8'h00 && !address_strobe_oe && !data_strobe_oe
        && !bus_read_nwrite_oe)
        else $error("bus not floated");
    a_bus_addr: assert property (!address_strobe_n && !st.cfg1[F1_FLOAT]
        |-> p1_oe == 8'hFF && p1_out == st.addr_lo)
        else $error("low address missing");
    a_hi_addr: assert property (!address_strobe_n && st.cfg1[F1_HIADDR]
        && !st.cfg1[F1_FLOAT] |-> p0_oe == 8'hFF && p0_out == st.addr_hi)
        else $error("upper address missing");
    a_p1_od: assert property (st.cfg0[F0_OD1] && st.state == ST_IDLE
        |-> p1_out == 8'h00 && (p1_oe & st.p1_data) == 8'h00)
        else $error("port 1 drove high");
    a_p2_od: assert property (st.cfg0[F0_OD2] |-> p2_out == 8'h00)
        else $error("port 2 drove high");
    a_p2_dir: assert property ((p2_oe & st.p2_dir) == 8'h00)
        else $error("port 2 input driven");
    a_p2_hs_send: assert property (req.wr && req.addr == OFF_P2_DATA
        && st.cfg0[F0_HS2] && !st.p2_dir[7] |=> !port3_line_six)
        else $error("port 2 data valid missing");
    a_p1_hs_send: assert property (req.wr && req.addr == OFF_P1_DATA
        && mode == PM_HS |=> !port3_line_four && hs1_pend)
        else $error("port 1 data valid missing");
    a_emi_sel: assert property (p1_low_emi == st.cfg0[F0_EMI1]
        && p2_low_emi == st.cfg0[F0_EMI2])
        else $error("low EMI select wrong");

endmodule

// ==== hw/padh_hs.sv ====
// One handshake channel: sends on software writes, receives into a latch.
// Assumes the partner line arrives already synchronised to clk.
`timescale 1ns/1ps

module padh_hs #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic dir_in,
    input wire logic load,
    input wire logic take,
    input wire logic partner,
    input wire logic [W-1:0] pins,
    output logic hs_out,
    output logic pending,
    output logic [W-1:0] latched
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic pend; // Transfer outstanding
        logic line; // Our handshake line
        logic prev; // Partner level last cycle
        logic [W-1:0] data; // Received word
    } padh_hs_st_t;

    padh_hs_st_t st; // Registered state
    padh_hs_st_t nxt; // Next state

    initial begin
        if (W < 1) begin
            $error("padh_hs: width must be at least one");
        end
    end

    // Handshake sequencing
    always_comb begin
        nxt = st;
        nxt.prev = partner;
        if (!en) begin
            // Idle channel keeps its line inactive high
            nxt.pend = 1'b0;
            nxt.line = 1'b1;
        end else if (!dir_in) begin
            // Sender: data-available low until a ready rise
            if (st.pend && partner && !st.prev) begin
                nxt.pend = 1'b0;
                nxt.line = 1'b1;
            end
            if (load) begin
                // New data wins over a same-cycle ready
                nxt.pend = 1'b1;
                nxt.line = 1'b0;
            end
        end else begin
            // Receiver: line is ready, high while empty
            if (take) begin
                nxt.pend = 1'b0;
                nxt.line = 1'b1;
            end
            if (!st.pend && !partner) begin
                // Capture wins over a same-cycle take
                nxt.pend = 1'b1;
                nxt.line = 1'b0;
                nxt.data = pins;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{line: 1'b1, prev: 1'b1, default: '0};
        end else begin
            st <= nxt;
        end
    end

    assign hs_out = st.line;
    assign pending = st.pend;
    assign latched = st.data;

endmodule

// ==== hw/padh_pkg.sv ====
// Shared constants and types for the address/data handshake port block.
// Assumes a 250 MHz core clock and an 8-bit register port.
package padh_pkg;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4; // Core clock period
    localparam int T_ADDR_SETUP_NS = 25; // Address valid to strobe fall
    localparam int T_AS_LOW_NS = 40; // Address strobe low width
    localparam int T_AS_TO_DS_NS = 45; // Address strobe rise to data strobe
    localparam int T_DS_READ_NS = 135; // Data strobe low, read
    localparam int T_DS_WRITE_NS = 80; // Data strobe low, write
    localparam int T_DS_HOLD_NS = 35; // Data strobe rise to next change
    localparam int EXT_EXTRA_PERIODS = 2; // Extended timing add-on

    // Least times round up to whole cycles
    localparam logic [7:0] C_ADDR_SETUP =
        8'((T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_AS_LOW =
        8'((T_AS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_AS_TO_DS =
        8'((T_AS_TO_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_DS_READ =
        8'((T_DS_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_DS_WRITE =
        8'((T_DS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_DS_HOLD =
        8'((T_DS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_EXT = 8'(EXT_EXTRA_PERIODS);

    // -------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------
    localparam logic [3:0] OFF_P1_DATA = 4'h0;
    localparam logic [3:0] OFF_P1_DIR = 4'h1;
    localparam logic [3:0] OFF_P2_DATA = 4'h2;
    localparam logic [3:0] OFF_P2_DIR = 4'h3;
    localparam logic [3:0] OFF_CFG0 = 4'h4;
    localparam logic [3:0] OFF_CFG1 = 4'h5;
    localparam logic [3:0] OFF_BUS_ADDR_LO = 4'h6;
    localparam logic [3:0] OFF_BUS_ADDR_HI = 4'h7;
    localparam logic [3:0] OFF_BUS_WDATA = 4'h8;
    localparam logic [3:0] OFF_BUS_CTRL = 4'h9;
    localparam logic [3:0] OFF_BUS_RDATA = 4'hA;
    localparam logic [3:0] OFF_HS_STAT = 4'hB;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int F0_MODE_LO = 0; // Port 1 mode, two bits
    localparam int F0_HS2 = 2; // Port 2 handshake enable
    localparam int F0_OD1 = 3; // Port 1 open-drain
    localparam int F0_OD2 = 4; // Port 2 open-drain
    localparam int F0_EMI1 = 5; // Port 1 low EMI drive
    localparam int F0_EMI2 = 6; // Port 2 low EMI drive
    localparam int F0_EXT = 7; // Extended bus timing
    localparam int F1_FLOAT = 0; // Release the shared bus
    localparam int F1_HIADDR = 1; // Port 0 drives upper address
    localparam int FC_START = 0; // Control: start a cycle
    localparam int FC_READ = 1; // Control: cycle is a read

    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_DIR = 8'hFF; // All lines inputs
    localparam logic [7:0] RST_CFG = 8'h00;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_IO = 2'b00,
        PM_BUS = 2'b01,
        PM_HS = 2'b10
    } padh_p1_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AS = 3'b010,
        ST_GAP = 3'b011,
        ST_DS = 3'b100,
        ST_END = 3'b101
    } padh_bus_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } padh_req_t;

endpackage
